// ---- rtl/ppm_pkg.sv ----
// package of the port 3 comparator and pin mux block
// register offsets, field positions, reset values and shared types;
// assumes a 32-bit apb bus with byte addresses
package ppm_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_TIMER8_CTL = 8'h00;
  localparam logic [7:0] OFS_TIMER_SHARED_CTL = 8'h04;
  localparam logic [7:0] OFS_TIMER16_CTL = 8'h08;
  localparam logic [7:0] OFS_PORT_CFG = 8'h0C;
  localparam logic [7:0] OFS_PORT3_MODE = 8'h10;
  localparam logic [7:0] OFS_PORT3_IN = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_STOP_RECOVERY = 8'h20;
  localparam logic [7:0] OFS_PORT3_OUT = 8'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int T8_ROUTE_BIT = 0;
  localparam int T16_ROUTE_BIT = 0;
  localparam int COMB_EN_BIT = 6;
  localparam int COMB_FN_LSB = 4;
  localparam int COMP_ROUTE_BIT = 0;
  localparam int ANALOG_BIT = 1;
  localparam int SMR_SEL_LSB = 0;
  localparam int IN_REF_A = 0;
  localparam int IN_ANA_A = 1;
  localparam int IN_ANA_B = 2;
  localparam int IN_REF_B = 3;
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;
  localparam int IRQ_C = 2;
  localparam int NUM_IRQ = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [3:0] RST_PINS = 4'h0;
  localparam logic [NUM_IRQ-1:0] RST_IRQ = 3'h0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PPM_COMB_AND = 2'h0,
    PPM_COMB_OR = 2'h1,
    PPM_COMB_NOR = 2'h2,
    PPM_COMB_NAND = 2'h3
  } ppm_comb_e;

  typedef enum logic [1:0] {
    PPM_SMR_EXT = 2'h0,
    PPM_SMR_ANA_A = 2'h1,
    PPM_SMR_ANA_B = 2'h2,
    PPM_SMR_REF_B = 2'h3
  } ppm_smr_e;

  typedef struct packed {
    logic [7:0] timer8_ctl;
    logic [7:0] timer_shared_ctl;
    logic [7:0] timer16_ctl;
    logic [7:0] port_cfg;
    logic [7:0] port3_mode;
    logic [7:0] stop_recovery;
    logic [7:0] port3_out;
    logic [NUM_IRQ-1:0] irq_mask;
  } ppm_regs_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } ppm_apb_req_s;

endpackage

// ---- rtl/ppm_edge_det.sv ----
// per-bit edge detector for the port 3 interrupt sources
// assumes inputs synchronous to clk_i; edges are held off for the
// first cycle after reset so pins already high do not fire
`timescale 1ns/1ns
`default_nettype none
module ppm_edge_det #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // levels in, one-cycle pulses out
  input wire logic [WIDTH-1:0] level_i,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  typedef struct packed {
    logic armed;
    logic [WIDTH-1:0] prev;
  } ppm_edge_s;

  ppm_edge_s st_r;
  ppm_edge_s st_nxt;

  always_comb begin
    st_nxt.armed = 1'b1;
    st_nxt.prev = level_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign rise_o[g] = st_r.armed & level_i[g] & ~st_r.prev[g];
      assign fall_o[g] = st_r.armed & ~level_i[g] & st_r.prev[g];
    end
  endgenerate

endmodule
`default_nettype wire

// ---- rtl/ppm_pin_mux.sv ----
// port 3 comparator and pin function multiplexer, apb register slave
// assumes timer outputs, comparator outputs and pins are synchronous
// to ref_clk_i; the analog front ends live in the pad ring
//
// Function
// - analog mode feeds input pins to comparators
// - analog mode takes references from reference pins
// - analog mode diverts third pin to recovery logic
// - digital mode: third pin is D3, raises int b
// - stop mode powers down and invalidates comparators
// - comparator outputs selectable onto pins four, seven
// - timer outputs and combined logic routed to pins
// - control bit zero routes each timer output
// - shared control D6 enables combined, D5-D4 function
// - mode bit one picks int b source
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ppm_pin_mux
  import ppm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // port 3 input pins: ref_a, analog_in_a, analog_in_b, ref_b
  input wire logic [3:0] pin_in_i,
  // comparator front ends
  input wire logic comp_a_i,
  input wire logic comp_b_i,
  output logic analog_sel_o,
  output logic comp_power_o,
  // timers and power state
  input wire logic timer8_out_i,
  input wire logic timer16_out_i,
  input wire logic stop_mode_i,
  input wire logic smr_ext_i,
  output logic stop_wake_o,
  // port 3 output pins 4..7
  output logic [3:0] pin_out_o,
  // interrupts
  output logic ext_int_a_o,
  output logic ext_int_b_o,
  output logic ext_int_c_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ppm_regs_s regs;
    logic [NUM_IRQ-1:0] irq_status;
    logic [NUM_IRQ-1:0] rd_capture;
    logic [31:0] rdata;
    logic [3:0] pins;
  } ppm_state_s;

  ppm_state_s st_r;
  ppm_state_s st_nxt;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic comb_fn(input logic [1:0] fn, input logic a,
                                   input logic b);
    logic res;
    res = 1'b0;
    unique case (ppm_comb_e'(fn))
      PPM_COMB_AND: res = a & b;
      PPM_COMB_OR: res = a | b;
      PPM_COMB_NOR: res = ~(a | b);
      PPM_COMB_NAND: res = ~(a & b);
    endcase
    return res;
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      OFS_TIMER8_CTL, OFS_TIMER_SHARED_CTL, OFS_TIMER16_CTL,
      OFS_PORT_CFG, OFS_PORT3_MODE, OFS_PORT3_IN, OFS_IRQ_STATUS,
      OFS_IRQ_MASK, OFS_STOP_RECOVERY, OFS_PORT3_OUT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // mode decode and comparator gating
  // ----------------------------------------------------------------
  logic analog;
  logic comp_valid;
  logic comp_a;
  logic comp_b;

  assign analog = st_r.regs.port3_mode[ANALOG_BIT];
  // pins go to comparator front ends, reference pins to their refs
  assign analog_sel_o = analog;
  // comparators are off in stop, so their outputs are forced low
  assign comp_valid = analog & ~stop_mode_i;
  assign comp_power_o = comp_valid;
  assign comp_a = comp_a_i & comp_valid;
  assign comp_b = comp_b_i & comp_valid;

  // ----------------------------------------------------------------
  // stop mode recovery source logic
  // ----------------------------------------------------------------
  // in analog mode the first two inputs are comparator inputs and
  // read as idle high here; software must pick digital mode first
  logic smr_src;

  always_comb begin
    smr_src = 1'b1;
    unique case (ppm_smr_e'(st_r.regs.stop_recovery[SMR_SEL_LSB +: 2]))
      PPM_SMR_EXT: smr_src = smr_ext_i;
      PPM_SMR_ANA_A: smr_src = analog | pin_in_i[IN_ANA_A];
      PPM_SMR_ANA_B: smr_src = analog | pin_in_i[IN_ANA_B];
      PPM_SMR_REF_B: smr_src = pin_in_i[IN_REF_B];
    endcase
  end

  assign stop_wake_o = stop_mode_i & ~smr_src;

  // ----------------------------------------------------------------
  // interrupt sources
  // ----------------------------------------------------------------
  // int b follows the third pin in digital mode and the recovery
  // logic in analog mode; a mode change may itself look like an edge
  logic [NUM_IRQ-1:0] src_lvl;
  logic [NUM_IRQ-1:0] src_rise;
  logic [NUM_IRQ-1:0] src_fall;
  logic [NUM_IRQ-1:0] events;

  always_comb begin
    src_lvl = '0;
    src_lvl[IRQ_A] = pin_in_i[IN_ANA_B];
    src_lvl[IRQ_C] = pin_in_i[IN_ANA_A];
    src_lvl[IRQ_B] = analog ? smr_src : pin_in_i[IN_REF_B];
  end

  ppm_edge_det #(
    .WIDTH(NUM_IRQ)
  ) i_ppm_edge_det (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(src_lvl),
    .rise_o(src_rise),
    .fall_o(src_fall)
  );

  always_comb begin
    events = '0;
    events[IRQ_A] = ~analog & (src_rise[IRQ_A] | src_fall[IRQ_A]);
    events[IRQ_C] = ~analog & (src_rise[IRQ_C] | src_fall[IRQ_C]);
    // falling edge only; diverted to recovery logic in analog mode
    events[IRQ_B] = src_fall[IRQ_B];
  end

  assign ext_int_a_o = events[IRQ_A];
  assign ext_int_b_o = events[IRQ_B];
  assign ext_int_c_o = events[IRQ_C];
  assign irq_o = |(st_r.irq_status & st_r.regs.irq_mask);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // no wait states: read data is registered in the setup cycle and
  // the access phase always completes in its first cycle
  logic setup;
  logic access;
  logic hit;

  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign hit = addr_hit(paddr_i);
  assign pready_o = access;
  assign pslverr_o = access & ~hit;
  assign prdata_o = st_r.rdata;

  // port 3 input register view; in analog mode the comparator
  // results stand in for the first two inputs and D3 is diverted
  logic [3:0] in_view;

  always_comb begin
    in_view = pin_in_i;
    if (analog) begin
      in_view[IN_ANA_A] = comp_a;
      in_view[IN_ANA_B] = comp_b;
      in_view[IN_REF_B] = 1'b0;
    end else begin
      in_view[IN_REF_B] = pin_in_i[IN_REF_B];
    end
  end

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (paddr_i)
      OFS_TIMER8_CTL: rd_mux[7:0] = st_r.regs.timer8_ctl;
      OFS_TIMER_SHARED_CTL: rd_mux[7:0] = st_r.regs.timer_shared_ctl;
      OFS_TIMER16_CTL: rd_mux[7:0] = st_r.regs.timer16_ctl;
      OFS_PORT_CFG: rd_mux[7:0] = st_r.regs.port_cfg;
      OFS_PORT3_MODE: rd_mux[7:0] = st_r.regs.port3_mode;
      OFS_PORT3_IN: rd_mux[3:0] = in_view;
      OFS_IRQ_STATUS: rd_mux[NUM_IRQ-1:0] = st_r.irq_status;
      OFS_IRQ_MASK: rd_mux[NUM_IRQ-1:0] = st_r.regs.irq_mask;
      OFS_STOP_RECOVERY: rd_mux[7:0] = st_r.regs.stop_recovery;
      OFS_PORT3_OUT: rd_mux[7:0] = st_r.regs.port3_out;
      default: rd_mux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // output pin routing
  // ----------------------------------------------------------------
  // timer routing has priority over the comparator on pin four
  logic [3:0] pins_nxt;
  logic [1:0] comb_sel;

  assign comb_sel = st_r.regs.timer_shared_ctl[COMB_FN_LSB +: 2];

  always_comb begin
    pins_nxt = st_r.regs.port3_out[7:4];
    if (st_r.regs.timer8_ctl[T8_ROUTE_BIT]) begin
      pins_nxt[0] = timer8_out_i;
    end else if (st_r.regs.port_cfg[COMP_ROUTE_BIT]) begin
      pins_nxt[0] = comp_a;
    end
    if (st_r.regs.timer16_ctl[T16_ROUTE_BIT]) begin
      pins_nxt[1] = timer16_out_i;
    end
    if (st_r.regs.timer_shared_ctl[COMB_EN_BIT]) begin
      pins_nxt[2] = comb_fn(comb_sel, timer8_out_i,
                            timer16_out_i);
    end
    if (st_r.regs.port_cfg[COMP_ROUTE_BIT]) begin
      pins_nxt[3] = comp_b;
    end
  end

  assign pin_out_o = st_r.pins;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.pins = pins_nxt;
    if (setup) begin
      st_nxt.rdata = rd_mux;
      st_nxt.rd_capture = (paddr_i == OFS_IRQ_STATUS && !pwrite_i) ?
                          st_r.irq_status : '0;
    end
    if (access && hit && pwrite_i) begin
      unique case (paddr_i)
        OFS_TIMER8_CTL: st_nxt.regs.timer8_ctl = pwdata_i[7:0];
        OFS_TIMER_SHARED_CTL: st_nxt.regs.timer_shared_ctl = pwdata_i[7:0];
        OFS_TIMER16_CTL: st_nxt.regs.timer16_ctl = pwdata_i[7:0];
        OFS_PORT_CFG: st_nxt.regs.port_cfg = pwdata_i[7:0];
        OFS_PORT3_MODE: st_nxt.regs.port3_mode = pwdata_i[7:0];
        OFS_IRQ_MASK: st_nxt.regs.irq_mask = pwdata_i[NUM_IRQ-1:0];
        OFS_STOP_RECOVERY: st_nxt.regs.stop_recovery = pwdata_i[7:0];
        OFS_PORT3_OUT: st_nxt.regs.port3_out = pwdata_i[7:0];
        default: st_nxt.regs = st_r.regs;
      endcase
    end
    // only bits shown to the reader are cleared; a new event wins
    if (access && !pwrite_i && paddr_i == OFS_IRQ_STATUS) begin
      st_nxt.irq_status = (st_r.irq_status & ~st_r.rd_capture) | events;
    end else begin
      st_nxt.irq_status = st_r.irq_status | events;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r.regs.timer8_ctl <= RST_CTL;
      st_r.regs.timer_shared_ctl <= RST_CTL;
      st_r.regs.timer16_ctl <= RST_CTL;
      st_r.regs.port_cfg <= RST_CTL;
      st_r.regs.port3_mode <= RST_CTL;
      st_r.regs.stop_recovery <= RST_CTL;
      st_r.regs.port3_out <= RST_CTL;
      st_r.regs.irq_mask <= RST_IRQ;
      st_r.irq_status <= RST_IRQ;
      st_r.rd_capture <= RST_IRQ;
      st_r.rdata <= RST_RDATA;
      st_r.pins <= RST_PINS;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- bench/ppm_pin_model.sv ----
// model of the circuitry outside the port 3 pins and comparator pads
// assumes the bench picks pin levels; analog values are coarse digital
`timescale 1ns/1ns
`default_nettype none
module ppm_pin_model (
  // clock and bench levels
  input wire logic ref_clk_i,
  input wire logic [3:0] lvl_i,
  input wire logic comp_power_i,
  // pins and comparator results
  output logic [3:0] pin_in_o,
  output logic comp_a_o,
  output logic comp_b_o
);
  // ----------------------------------------------------------------
  // pads and front ends
  // ----------------------------------------------------------------
  logic junk_r = 1'b0;
  always @(posedge ref_clk_i) junk_r <= ~junk_r;
  assign pin_in_o = lvl_i;
  // an unpowered front end has no valid result, so it flips each cycle
  assign comp_a_o = comp_power_i ? (lvl_i[1] & ~lvl_i[0]) :
                    junk_r;
  assign comp_b_o = comp_power_i ? (lvl_i[2] & ~lvl_i[3]) :
                    ~junk_r;
endmodule
`default_nettype wire

// ---- bench/ppm_pin_mux_sva.sv ----
// checker for the port 3 pin mux, bound to the top module's ports
// assumes one clock domain; routing registers shadowed from apb writes
`timescale 1ns/1ns
`default_nettype none
module ppm_pin_mux_sva
  import ppm_pkg::*;
(
  // clock, reset and apb
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  // pins, comparators, timers and interrupts
  input wire logic [3:0] pin_in_i,
  input wire logic comp_a_i,
  input wire logic comp_b_i,
  input wire logic analog_sel_o,
  input wire logic comp_power_o,
  input wire logic timer8_out_i,
  input wire logic timer16_out_i,
  input wire logic stop_mode_i,
  input wire logic stop_wake_o,
  input wire logic [3:0] pin_out_o,
  input wire logic ext_int_a_o,
  input wire logic ext_int_b_o,
  input wire logic ext_int_c_o
);
  // ----------------------------------------------------------------
  // register shadows and assertions
  // ----------------------------------------------------------------
  logic [7:0] t8_r, sh_r, t16_r, cfg_r, md_r;
  logic live_r, wr, cmb;
  assign wr = psel_i && penable_i && pwrite_i && pready_o;
  // base function is and/or, the upper code bit inverts it
  assign cmb = ((sh_r[5] ^ sh_r[4]) ? (timer8_out_i | timer16_out_i)
    : (timer8_out_i & timer16_out_i)) ^ sh_r[5];
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {t8_r, sh_r, t16_r, cfg_r, md_r} <= '0;
      live_r <= 1'b0;
    end else begin
      live_r <= 1'b1;
      if (wr && paddr_i == OFS_TIMER8_CTL) t8_r <= pwdata_i[7:0];
      if (wr && paddr_i == OFS_TIMER_SHARED_CTL) sh_r <= pwdata_i[7:0];
      if (wr && paddr_i == OFS_TIMER16_CTL) t16_r <= pwdata_i[7:0];
      if (wr && paddr_i == OFS_PORT_CFG) cfg_r <= pwdata_i[7:0];
      if (wr && paddr_i == OFS_PORT3_MODE) md_r <= pwdata_i[7:0];
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_RST_IDLE: assert property (
    !live_r |-> pin_out_o == 4'h0 && !analog_sel_o) else $error("not idle");
  AST_T8_ROUTE: assert property (
    $past(t8_r[0]) |-> pin_out_o[0] == $past(timer8_out_i))
    else $error("pin4 not timer8");
  AST_T16_ROUTE: assert property (
    $past(t16_r[0]) |-> pin_out_o[1] == $past(timer16_out_i))
    else $error("pin5 not timer16");
  AST_COMB_ROUTE: assert property (
    $past(sh_r[6]) |-> pin_out_o[2] == $past(cmb)) else $error("pin6 bad");
  AST_CMP_B: assert property (
    $past(cfg_r[0]) |-> pin_out_o[3] == $past(comp_b_i && comp_power_o))
    else $error("pin7 not comparator b");
  AST_CMP_A: assert property (
    $past(cfg_r[0] && !t8_r[0])
    |-> pin_out_o[0] == $past(comp_a_i && comp_power_o))
    else $error("pin4 not comparator a");
  AST_MODE: assert property (
    analog_sel_o == md_r[ANALOG_BIT]) else $error("mode select wrong");
  AST_POWER: assert property (
    comp_power_o == (analog_sel_o && !stop_mode_i)) else $error("power");
  AST_ANA_QUIET: assert property (
    analog_sel_o && $past(analog_sel_o) |-> !ext_int_a_o && !ext_int_c_o)
    else $error("digital interrupt in analog mode");
  AST_INT_B: assert property (
    $past(live_r) && !analog_sel_o && !$past(analog_sel_o)
    && $fell(pin_in_i[IN_REF_B]) |-> ext_int_b_o) else $error("no int b");
  AST_WAKE: assert property (
    !stop_mode_i |-> !stop_wake_o) else $error("wake outside stop");
endmodule
bind ppm_pin_mux ppm_pin_mux_sva i_ppm_pin_mux_sva (.*);
`default_nettype wire

// ---- bench/ppm_pin_mux_tb_top.sv ----
// self-checking bench for the port 3 pin mux
// assumes apb answers come in the design's own time, one clock domain
`timescale 1ns/1ns
`default_nettype none
module ppm_pin_mux_tb_top
  import ppm_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus, instances and checks
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] t8, sh, t16, cfg, md, odat;
    logic ti8, ti16, stop;
    logic [3:0] lvl, pout;
    logic pwr;
  } ppm_row_s;
  ppm_apb_req_s req = '0;
  logic clk = 1'b0, rst_n = 1'b0, pready, pslverr, err, ca, cb, asel, pwr;
  logic t8 = 1'b0, t16 = 1'b0, stop = 1'b0, sext = 1'b1;
  logic wake, ia, ib, ic, irq;
  logic [31:0] prdata, rd;
  logic [3:0] lvl = 4'h0, pins, pout;
  int bad_count = 0, n_compared = 0;
  ppm_row_s rows [12];
  always #5 clk = ~clk;
  ppm_pin_model i_ppm_pin_model (.ref_clk_i(clk), .lvl_i(lvl),
    .comp_power_i(pwr), .pin_in_o(pins), .comp_a_o(ca), .comp_b_o(cb));
  ppm_pin_mux i_ppm_pin_mux (.ref_clk_i(clk), .rst_n_i(rst_n),
    .psel_i(req.psel), .penable_i(req.penable), .pwrite_i(req.pwrite),
    .paddr_i(req.paddr), .pwdata_i(req.pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pin_in_i(pins),
    .comp_a_i(ca), .comp_b_i(cb), .analog_sel_o(asel),
    .comp_power_o(pwr), .timer8_out_i(t8), .timer16_out_i(t16),
    .stop_mode_i(stop), .smr_ext_i(sext), .stop_wake_o(wake),
    .pin_out_o(pout), .ext_int_a_o(ia), .ext_int_b_o(ib),
    .ext_int_c_o(ic), .irq_o(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    // no cycle limit here: a hung slave is caught by the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  initial begin
    #100000;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    rows = '{
      '{8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,1'b1,1'b1,1'b0,4'h0,4'h0,1'b0},
      '{8'h01,8'h00,8'h00,8'h00,8'h00,8'h00,1'b1,1'b1,1'b0,4'h0,4'h1,1'b0},
      '{8'h00,8'h00,8'h01,8'h00,8'h00,8'h00,1'b1,1'b1,1'b0,4'h0,4'h2,1'b0},
      '{8'h00,8'h40,8'h00,8'h00,8'h00,8'h00,1'b1,1'b0,1'b0,4'h0,4'h0,1'b0},
      '{8'h00,8'h50,8'h00,8'h00,8'h00,8'h00,1'b1,1'b0,1'b0,4'h0,4'h4,1'b0},
      '{8'h00,8'h60,8'h00,8'h00,8'h00,8'h00,1'b1,1'b0,1'b0,4'h0,4'h0,1'b0},
      '{8'h00,8'h70,8'h00,8'h00,8'h00,8'h00,1'b1,1'b0,1'b0,4'h0,4'h4,1'b0},
      '{8'h00,8'h00,8'h00,8'h01,8'h02,8'h00,1'b0,1'b0,1'b0,4'h6,4'h9,1'b1},
      '{8'h00,8'h00,8'h00,8'h01,8'h02,8'h00,1'b0,1'b0,1'b1,4'h6,4'h0,1'b0},
      '{8'h00,8'h00,8'h00,8'h01,8'h00,8'h00,1'b0,1'b0,1'b0,4'h6,4'h0,1'b0},
      '{8'h01,8'h00,8'h00,8'h01,8'h02,8'h00,1'b0,1'b0,1'b0,4'h6,4'h8,1'b1},
      '{8'h00,8'h00,8'h00,8'h00,8'h00,8'hF0,1'b0,1'b0,1'b0,4'h0,4'hF,1'b0}};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'(asel), 32'h0);
    for (int a = 0; a < 10; a++) begin
      apb(1'b0, 8'(a * 4), 8'h00);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h28, 8'h00);
    chk(32'(err), 32'h1);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, OFS_TIMER8_CTL, rows[i].t8);
      apb(1'b1, OFS_TIMER_SHARED_CTL, rows[i].sh);
      apb(1'b1, OFS_TIMER16_CTL, rows[i].t16);
      apb(1'b1, OFS_PORT_CFG, rows[i].cfg);
      apb(1'b1, OFS_PORT3_MODE, rows[i].md);
      apb(1'b1, OFS_PORT3_OUT, rows[i].odat);
      t8 <= rows[i].ti8;
      t16 <= rows[i].ti16;
      stop <= rows[i].stop;
      lvl <= rows[i].lvl;
      repeat (2) @(posedge clk);
      chk(32'(pout), 32'(rows[i].pout));
      chk(32'(pwr), 32'(rows[i].pwr));
      $display("row %0d done", i);
    end
    apb(1'b1, OFS_PORT3_MODE, 8'h00);
    apb(1'b1, OFS_IRQ_MASK, 8'h02);
    lvl <= 4'h8;
    apb(1'b0, OFS_IRQ_STATUS, 8'h00);
    apb(1'b0, OFS_PORT3_IN, 8'h00);
    chk(rd, 32'h8);
    lvl <= 4'h0;
    @(posedge clk);
    chk(32'(ib), 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    apb(1'b0, OFS_IRQ_STATUS, 8'h00);
    chk(rd, 32'h2);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    lvl <= 4'h6;
    @(posedge clk);
    chk(32'({ic, ia}), 32'h3);
    @(posedge clk);
    apb(1'b0, OFS_IRQ_STATUS, 8'h00);
    chk(rd, 32'h5);
    $display("digital interrupt test done");
    apb(1'b1, OFS_PORT3_MODE, 8'h02);
    apb(1'b1, OFS_STOP_RECOVERY, 8'h00);
    // the mode switch may leave a stray int b edge behind
    apb(1'b0, OFS_IRQ_STATUS, 8'h00);
    lvl <= 4'hE;
    repeat (2) @(posedge clk);
    lvl <= 4'h0;
    repeat (3) @(posedge clk);
    apb(1'b0, OFS_IRQ_STATUS, 8'h00);
    chk(rd, 32'h0);
    sext <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, OFS_IRQ_STATUS, 8'h00);
    chk(rd, 32'h2);
    stop <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(wake), 32'h1);
    apb(1'b1, OFS_STOP_RECOVERY, 8'h01);
    chk(32'(wake), 32'h0);
    apb(1'b1, OFS_STOP_RECOVERY, 8'h03);
    chk(32'(wake), 32'h1);
    lvl <= 4'h8;
    repeat (2) @(posedge clk);
    chk(32'(wake), 32'h0);
    $display("analog interrupt test done");
    rst_n <= 1'b0;
    @(posedge clk);
    chk(32'(pout), 32'h0);
    chk(32'(asel | irq), 32'h0);
    rst_n <= 1'b1;
    apb(1'b0, OFS_PORT3_MODE, 8'h00);
    chk(rd, 32'h0);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
